/* File: hdl/ilmc_pkg.sv */
// shared constants for image load and mode control
package ilmc_pkg;
	// ****************************************
	// serial command addresses (first byte)
	// ****************************************
	localparam logic [7:0] ADR_GEN_RESET = 8'h01; // full reset, no data
	localparam logic [7:0] ADR_CSUM1_HI = 8'hA9;
	localparam logic [7:0] ADR_CSUM1_LO = 8'hAA;
	localparam logic [7:0] ADR_OUT_GAIN = 8'hB0;
	localparam logic [7:0] ADR_ROUTING = 8'hB1;
	localparam logic [7:0] ADR_CSUM2_HI = 8'hB8;
	localparam logic [7:0] ADR_CSUM2_LO = 8'hB9;
	localparam logic [7:0] ADR_POWER = 8'hC0;
	localparam logic [7:0] ADR_MODE = 8'hC1;
	localparam logic [7:0] ADR_RX_AUDIO = 8'hC2;
	localparam logic [7:0] ADR_TONE_SEL = 8'hC3;
	localparam logic [7:0] ADR_IDENT = 8'hC5;
	localparam logic [7:0] ADR_STATUS = 8'hC6;
	localparam logic [7:0] ADR_PARAM = 8'hC8;
	localparam logic [7:0] ADR_VERSION = 8'hC9;
	localparam logic [7:0] ADR_IMG_DATA = 8'hCA; // image word stream
	localparam logic [7:0] ADR_IMG_END = 8'hCB; // image complete
	localparam logic [7:0] ADR_TONE_STAT = 8'hCC;
	localparam logic [7:0] ADR_AUDIO = 8'hCD;
	localparam logic [7:0] ADR_ACTIVATE = 8'hCE; // activation code
	// ****************************************
	// fields and values
	// ****************************************
	localparam int ST_B_CFG = 0; // status: configuration access
	localparam int ST_B_RX = 1;
	localparam int ST_B_TX = 2;
	localparam int ST_B_LOAD = 3;
	localparam int MODE_B_RX = 0;
	localparam int MODE_B_TX = 1;
	localparam int RT_RX_LSB = 0; // routing: rx input source
	localparam int RT_TX_LSB = 2; // routing: tx input source
	localparam logic [15:0] DEAD_MARK = 16'hDEAD;
	localparam int IMG_BYTES = 46 * 1024;
	localparam int IMG_WORDS = IMG_BYTES / 2;
	// ****************************************
	// host controller registers (byte offsets)
	// ****************************************
	localparam logic [7:0] HR_CMD = 8'h00; // [7:0] addr, [9:8] data bytes
	localparam logic [7:0] HR_WDATA = 8'h04;
	localparam logic [7:0] HR_STAT = 8'h08; // [0] busy, [1] image overflow
	localparam logic [7:0] HR_RDATA = 8'h0C;
	localparam logic [7:0] HR_BOOT = 8'h10; // [1] high pin, [0] low pin
	// ****************************************
	// timing
	// ****************************************
	localparam int T_CLK_NS = 100;
	localparam int T_SCLK_HALF_NS = 400;
	localparam int T_CSOFF_NS = 1000;
	localparam int T_REPOLL_US = 250;
	localparam int N_SCLK_HALF = T_SCLK_HALF_NS / T_CLK_NS;
	localparam int N_CSOFF = (T_CSOFF_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int N_REPOLL = (T_REPOLL_US * 1000 + T_CLK_NS - 1) / T_CLK_NS;
	// read-only addresses answer with reply data
	function automatic logic ilmc_is_ro(input logic [7:0] a);
		return a == ADR_CSUM1_HI || a == ADR_CSUM1_LO || a == ADR_CSUM2_HI ||
			a == ADR_CSUM2_LO || a == ADR_IDENT || a == ADR_STATUS ||
			a == ADR_VERSION || a == ADR_TONE_STAT;
	endfunction
	// input amplifier select, one-hot; code 3 selects none
	function automatic logic [2:0] ilmc_amp(input logic [1:0] s);
		return (s == 2'd3) ? 3'b000 : 3'(3'b001 << s);
	endfunction
endpackage

/* File: hdl/ilmc_if.sv */
// link wires between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface ilmc_if;
	logic sclk; // serial clock, host made
	logic bus_select_n; // transaction frame, low active
	logic bus_command_in; // host to device data
	logic reply_out; // device reply data
	logic reply_oe; // device drives reply
	logic reply_line; // resolved reply wire
	logic boot_select_high_pin;
	logic boot_select_low_pin;
	// undriven reply line floats high
	assign reply_line = reply_oe ? reply_out : 1'b1;
	modport device (
		input sclk, bus_select_n, bus_command_in,
		input boot_select_high_pin, boot_select_low_pin,
		output reply_out, reply_oe
	);
	modport host (
		output sclk, bus_select_n, bus_command_in,
		output boot_select_high_pin, boot_select_low_pin,
		input reply_line
	);
endinterface
`default_nettype wire

/* File: hdl/ilmc_bus_rx.sv */
// serial command receiver and reply shifter of the device
`timescale 1ns/1ps
`default_nettype none
module ilmc_bus_rx (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// raw link pins
	input wire logic sclk_pin,
	input wire logic sel_n_pin,
	input wire logic din_pin,
	output logic dout,
	output logic dout_oe,
	// device side
	input wire logic [15:0] rd_word,
	input wire logic rd_enable,
	output logic [7:0] head,
	output logic [15:0] body,
	output logic [1:0] body_bytes,
	output logic done
);
	logic [2:0] sclk_s; // sync pair plus edge history
	logic [2:0] sel_s;
	logic [1:0] din_s;
	logic [4:0] nbits; // bits of this frame, saturates
	logic [23:0] sh; // received bits
	logic [15:0] rsh; // reply bits still to send
	wire sclk_rise = sclk_s[1] & ~sclk_s[2];
	wire sclk_fall = ~sclk_s[1] & sclk_s[2];
	wire active = ~sel_s[1];
	// command acts at end of frame
	assign done = sel_s[1] & ~sel_s[2];
	assign body = sh[15:0];
	assign body_bytes = (nbits >= 5'd24) ? 2'd2 : (nbits >= 5'd16) ? 2'd1 : 2'd0;
	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_s <= 3'b111;
			sel_s <= 3'b111;
			din_s <= 2'b00;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk_pin};
			sel_s <= {sel_s[1:0], sel_n_pin};
			din_s <= {din_s[0], din_pin};
		end
	end
	// ****************************************
	// receive shift, msb first on rising sclk
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nbits <= 5'd0;
			sh <= 24'h00_0000;
			head <= 8'h00;
		end else if (!active) begin
			nbits <= 5'd0; // framing restarts every select
		end else if (sclk_rise && nbits != 5'd24) begin
			sh <= {sh[22:0], din_s[1]};
			nbits <= nbits + 5'd1;
			if (nbits == 5'd7)
				head <= {sh[6:0], din_s[1]};
		end
	end
	// ****************************************
	// reply shift, changes on falling sclk
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout <= 1'b1;
			dout_oe <= 1'b0;
			rsh <= 16'h0000;
		end else if (!active) begin
			dout <= 1'b1;
			dout_oe <= 1'b0; // release once frame ends
		end else if (sclk_fall && nbits == 5'd8 && rd_enable) begin
			dout_oe <= 1'b1;
			dout <= rd_word[15];
			rsh <= {rd_word[14:0], 1'b0};
		end else if (sclk_fall && dout_oe) begin
			dout <= rsh[15];
			rsh <= {rsh[14:0], 1'b0};
		end
	end
endmodule // ilmc_bus_rx
`default_nettype wire

/* File: hdl/ilmc_device.sv */
// device end: image load, identity report and operating state
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - boot pins read at power-on, full reset
// - boot pins ignored after load completes
// - both high host load, both low none
// - image version readable after load
// - two 32-bit checksums in register pairs
// - load done: idle, ready, config flag set
// - activation clears checksum, identity, version
// - bad activation: mark, lock until power-on
// - reset with pins low keeps image
// - non-operational until image loaded
// - image at most 46 kilobytes
// - host checks checksums before activation
// - host configures then selects rx/tx
// - general reset with image kept and pins low ends in idle, blocks off
// - parameter register accepted in idle
// - rx, tx independent; none means idle
// - rx, tx inputs from three amplifiers
// - host spaces same-register writes 250 us, except image data writes
// - command acts on select rising edge
module ilmc_device
	import ilmc_pkg::*;
#(
	parameter logic [15:0] ID_CODE = 16'h0A11, // arbitrary value
	parameter logic [15:0] ACT_CODE = 16'h5EED, // arbitrary value
	parameter int MAX_WORDS = IMG_WORDS
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// serial link
	ilmc_if.device lnk,
	// operating state
	output logic operational,
	output logic idle_mode,
	output logic rx_active,
	output logic tx_active,
	output logic locked,
	// analogue setup
	output logic [15:0] power_enables,
	output logic [15:0] output_gain,
	output logic [2:0] rx_amp,
	output logic [2:0] tx_amp,
	// parameter programming
	output logic [15:0] param_word,
	output logic param_strobe
);
	// ****************************************
	// declarations
	// ****************************************
	typedef enum logic [2:0] {
		ST_OFF = 3'b000, // no image, non-operational
		ST_LOAD = 3'b001, // host streaming image
		ST_IDLE = 3'b010,
		ST_ACTIVE = 3'b011,
		ST_LOCK = 3'b100 // only power-on leaves
	} ilmc_state_e;
	ilmc_state_e state;
	ilmc_state_e next_state;
	logic [1:0] bh_s; // boot high pin sync
	logic [1:0] bl_s; // boot low pin sync
	logic [1:0] samp_cnt; // countdown to boot sampling
	logic [31:0] csum1;
	logic [31:0] csum2;
	logic [15:0] version;
	logic [14:0] nwords; // image words taken
	logic img_valid; // an image survives full reset
	logic show_ids; // identity values readable
	logic dead; // invalid activation seen
	logic [1:0] mode;
	logic [15:0] routing;
	logic [7:0] rx_head;
	logic [15:0] rx_body;
	logic [1:0] rx_bytes;
	logic rx_done;
	logic [15:0] rd_word;
	logic rd_enable;
	// ****************************************
	// serial receiver
	// ****************************************
	ilmc_bus_rx u_rx (
		.hclk(hclk),
		.hresetn(hresetn),
		.sclk_pin(lnk.sclk),
		.sel_n_pin(lnk.bus_select_n),
		.din_pin(lnk.bus_command_in),
		.dout(lnk.reply_out),
		.dout_oe(lnk.reply_oe),
		.rd_word(rd_word),
		.rd_enable(rd_enable),
		.head(rx_head),
		.body(rx_body),
		.body_bytes(rx_bytes),
		.done(rx_done)
	);
	// ****************************************
	// command decode
	// ****************************************
	wire ready = state == ST_IDLE || state == ST_ACTIVE;
	wire cmd = rx_done && state != ST_LOCK;
	wire wr = cmd && rx_bytes == 2'd2 && !ilmc_is_ro(rx_head);
	wire gen_rst = cmd && rx_head == ADR_GEN_RESET && rx_bytes == 2'd0;
	wire sample_now = samp_cnt == 2'd1;
	// boot code decode, reserved codes match neither
	wire boot_load = bh_s[1] & bl_s[1];
	wire boot_none = ~bh_s[1] & ~bl_s[1];
	wire load_start = state == ST_OFF && sample_now && boot_load;
	wire restart = state == ST_OFF && sample_now && boot_none && img_valid;
	wire load_end = wr && state == ST_LOAD && rx_head == ADR_IMG_END;
	wire img_wr = wr && state == ST_LOAD && rx_head == ADR_IMG_DATA &&
		nwords < 15'(MAX_WORDS);
	wire act_wr = wr && ready && rx_head == ADR_ACTIVATE;
	wire act_bad = act_wr && rx_body != ACT_CODE;
	wire mode_wr = wr && ready && rx_head == ADR_MODE;
	wire [15:0] id_mask = show_ids ? 16'hFFFF : 16'h0000;
	wire [15:0] status_word = {12'h000, state == ST_LOAD, mode, ready};
	// ****************************************
	// read selection
	// ****************************************
	assign rd_word =
		(rx_head == ADR_CSUM1_HI) ? (dead ? DEAD_MARK : csum1[31:16] & id_mask) :
		(rx_head == ADR_CSUM1_LO) ? csum1[15:0] & id_mask :
		(rx_head == ADR_CSUM2_HI) ? csum2[31:16] & id_mask :
		(rx_head == ADR_CSUM2_LO) ? csum2[15:0] & id_mask :
		(rx_head == ADR_IDENT) ? ID_CODE & id_mask :
		(rx_head == ADR_VERSION) ? version & id_mask :
		(rx_head == ADR_STATUS) ? status_word : 16'h0000;
	// a locked device still shows its mark, nothing else
	assign rd_enable = ilmc_is_ro(rx_head) && (state != ST_LOCK || rx_head == ADR_CSUM1_HI);
	// ****************************************
	// user side decode
	// ****************************************
	assign operational = ready;
	assign idle_mode = state == ST_IDLE;
	assign locked = state == ST_LOCK;
	assign rx_active = mode[MODE_B_RX];
	assign tx_active = mode[MODE_B_TX];
	assign rx_amp = ilmc_amp(routing[RT_RX_LSB +: 2]);
	assign tx_amp = ilmc_amp(routing[RT_TX_LSB +: 2]);
	// ****************************************
	// boot pin sync and sampling moment
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bh_s <= 2'b00;
			bl_s <= 2'b00;
		end else begin
			bh_s <= {bh_s[0], lnk.boot_select_high_pin};
			bl_s <= {bl_s[0], lnk.boot_select_low_pin};
		end
	end
	// pins look only once, after sync settles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			samp_cnt <= 2'd3;
		else if (gen_rst)
			samp_cnt <= 2'd3;
		else if (samp_cnt != 2'd0)
			samp_cnt <= samp_cnt - 2'd1;
	end
	// ****************************************
	// state machine
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (load_start || restart)
					next_state = restart ? ST_IDLE : ST_LOAD;
			end
			ST_LOAD: begin
				if (load_end)
					next_state = ST_IDLE;
			end
			ST_IDLE, ST_ACTIVE: begin
				if (mode_wr)
					next_state = (rx_body[1:0] != 2'b00) ? ST_ACTIVE : ST_IDLE;
			end
			ST_LOCK: next_state = ST_LOCK;
			default: next_state = ST_OFF;
		endcase
		if (gen_rst)
			next_state = ST_OFF;
		if (act_bad)
			next_state = ST_LOCK;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			state <= ST_OFF;
		else
			state <= next_state;
	end
	// ****************************************
	// image intake and checksums
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			csum1 <= 32'h0000_0000;
			csum2 <= 32'h0000_0000;
			version <= 16'h0000;
			nwords <= 15'd0;
		end else if (load_start) begin
			csum1 <= 32'h0000_0000;
			csum2 <= 32'h0000_0000;
			version <= 16'h0000;
			nwords <= 15'd0;
		end else if (img_wr) begin
			// additive sum plus rotate-xor, two views of one stream
			csum1 <= csum1 + {16'h0000, rx_body};
			csum2 <= {csum2[30:0], csum2[31]} ^ {16'h0000, rx_body};
			nwords <= nwords + 15'd1;
			if (nwords == 15'd0)
				version <= rx_body;
		end
	end
	// ****************************************
	// image flags
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			img_valid <= 1'b0;
			show_ids <= 1'b0;
			dead <= 1'b0;
		end else if (load_start) begin
			img_valid <= 1'b0;
			show_ids <= 1'b0;
		end else if (load_end || restart) begin
			img_valid <= 1'b1;
			show_ids <= 1'b1;
		end else if (act_wr) begin
			show_ids <= 1'b0;
			dead <= act_bad;
		end
	end
	// ****************************************
	// host-written control registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= 2'b00;
			power_enables <= 16'h0000;
			routing <= 16'hFFFF;
			output_gain <= 16'h0000;
		end else if (gen_rst || act_bad) begin
			mode <= 2'b00;
			power_enables <= 16'h0000;
			routing <= 16'hFFFF;
		end else if (wr && ready) begin
			if (rx_head == ADR_MODE)
				mode <= rx_body[1:0];
			if (rx_head == ADR_POWER)
				power_enables <= rx_body;
			if (rx_head == ADR_ROUTING)
				routing <= rx_body;
			if (rx_head == ADR_OUT_GAIN)
				output_gain <= rx_body;
		end
	end
	// parameter writes only while idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			param_word <= 16'h0000;
			param_strobe <= 1'b0;
		end else begin
			param_strobe <= wr && state == ST_IDLE && rx_head == ADR_PARAM;
			if (wr && state == ST_IDLE && rx_head == ADR_PARAM)
				param_word <= rx_body;
		end
	end
endmodule // ilmc_device
`default_nettype wire

/* File: hdl/ilmc_host.sv */
// host end: ahb-lite controlled serial command master
`timescale 1ns/1ps
`default_nettype none
module ilmc_host
	import ilmc_pkg::*;
#(
	parameter int HALF = N_SCLK_HALF,
	parameter int MAX_WORDS = IMG_WORDS
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// serial link
	ilmc_if.host lnk
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_HOLD = 3'b001, // repoll spacing
		H_LOW = 3'b010,
		H_HIGH = 3'b011,
		H_END = 3'b100,
		H_GAP = 3'b101
	} ilmc_hst_e;
	ilmc_hst_e hst;
	logic a_wr; // latched address phase
	logic [7:0] a_addr;
	logic [7:0] c_addr;
	logic [1:0] c_bytes;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [1:0] boot;
	logic ovf;
	logic [14:0] img_cnt;
	logic [7:0] last_wr;
	logic [11:0] holdoff;
	logic [7:0] ph_cnt;
	logic [4:0] bitn;
	logic [23:0] sh;
	logic [15:0] rsh;
	logic [1:0] rep_s; // reply sync
	logic sclk;
	logic sel_n;
	wire busy = hst != H_IDLE;
	wire tick = ph_cnt == 8'(HALF - 1);
	wire [4:0] nbits = {c_bytes, 3'b000} + 5'd8;
	wire c_is_wr = c_bytes == 2'd2 && !ilmc_is_ro(c_addr);
	wire wr_cmd = a_wr && a_addr == HR_CMD && !busy;
	wire img_full = hwdata[7:0] == ADR_IMG_DATA && img_cnt >= 15'(MAX_WORDS);
	// same register waits out the device poll period; image stream exempt
	wire must_wait = c_is_wr && c_addr == last_wr && c_addr != ADR_IMG_DATA &&
		holdoff != 12'd0;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign lnk.sclk = sclk;
	assign lnk.bus_select_n = sel_n;
	assign lnk.bus_command_in = sh[23];
	assign lnk.boot_select_high_pin = boot[1];
	assign lnk.boot_select_low_pin = boot[0];
	// ****************************************
	// ahb slave, zero wait
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr <= 1'b0;
			a_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			a_wr <= hsel && htrans[1] && hready && hwrite;
			a_addr <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite)
				hrdata <= (haddr[7:0] == HR_STAT) ? {30'h0000_0000, ovf, busy} :
					(haddr[7:0] == HR_RDATA) ? {16'h0000, rdata} :
					(haddr[7:0] == HR_BOOT) ? {30'h0000_0000, boot} : 32'h0000_0000;
		end
	end
	// ****************************************
	// software registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdata <= 16'h0000;
			boot <= 2'b11;
			c_addr <= 8'h00;
			c_bytes <= 2'd0;
		end else if (a_wr) begin
			if (a_addr == HR_WDATA)
				wdata <= hwdata[15:0];
			// reserved pin codes never reach the pins
			if (a_addr == HR_BOOT && hwdata[1] == hwdata[0])
				boot <= hwdata[1:0];
			if (wr_cmd) begin
				c_addr <= hwdata[7:0];
				c_bytes <= hwdata[9:8];
			end
		end
	end
	// ****************************************
	// link engine
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hst <= H_IDLE;
			ph_cnt <= 8'd0;
			bitn <= 5'd0;
			sh <= 24'h00_0000;
			rsh <= 16'h0000;
			sclk <= 1'b1;
			sel_n <= 1'b1;
		end else begin
			ph_cnt <= tick ? 8'd0 : ph_cnt + 8'd1;
			case (hst)
				H_IDLE: if (wr_cmd && !img_full) begin
					hst <= H_HOLD;
					sh <= {hwdata[7:0], wdata};
				end
				H_HOLD: if (!must_wait) begin
					hst <= H_LOW;
					sel_n <= 1'b0;
					sclk <= 1'b0;
					ph_cnt <= 8'd0;
					bitn <= 5'd0;
				end
				H_LOW: if (tick) begin
					hst <= H_HIGH;
					sclk <= 1'b1;
					bitn <= bitn + 5'd1;
				end
				H_HIGH: if (tick) begin
					rsh <= {rsh[14:0], rep_s[1]};
					hst <= (bitn == nbits) ? H_END : H_LOW;
					if (bitn != nbits) begin
						sclk <= 1'b0;
						sh <= {sh[22:0], 1'b0};
					end
				end
				H_END: if (tick) begin
					hst <= H_GAP;
					sel_n <= 1'b1;
				end
				// the gap counts on past a half period, so no wrap here
				H_GAP: begin
					ph_cnt <= ph_cnt + 8'd1;
					if (ph_cnt == 8'(N_CSOFF - 1))
						hst <= H_IDLE;
				end
				default: hst <= H_IDLE;
			endcase
		end
	end
	// ****************************************
	// reply sync and completion bookkeeping
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rep_s <= 2'b11;
			rdata <= 16'h0000;
			ovf <= 1'b0;
			img_cnt <= 15'd0;
			last_wr <= 8'h00;
			holdoff <= 12'd0;
		end else begin
			rep_s <= {rep_s[0], lnk.reply_line};
			if (holdoff != 12'd0)
				holdoff <= holdoff - 12'd1;
			if (a_wr && a_addr == HR_BOOT)
				img_cnt <= 15'd0;
			if (wr_cmd && img_full)
				ovf <= 1'b1;
			if (hst == H_END && tick) begin
				rdata <= rsh;
				if (c_is_wr) begin
					last_wr <= c_addr;
					holdoff <= 12'(N_REPOLL);
				end
				if (c_is_wr && c_addr == ADR_IMG_DATA)
					img_cnt <= img_cnt + 15'd1;
			end
		end
	end
endmodule // ilmc_host
`default_nettype wire

/* File: verification/ilmc_checker.sv */
// link wire assertions for the host and device ends
`timescale 1ns/1ps
`default_nettype none
module ilmc_checker (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// link wires
	input wire logic sclk,
	input wire logic bus_select_n,
	input wire logic bus_command_in,
	input wire logic reply_out,
	input wire logic reply_oe,
	input wire logic reply_line,
	input wire logic boot_select_high_pin,
	input wire logic boot_select_low_pin
);
	// ****
	// checks
	// ****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// boot pin pair as one code
	wire logic [1:0] boot = {boot_select_high_pin, boot_select_low_pin};
	a_reply_release: assert property ($rose(bus_select_n) |-> ##[0:10] !reply_oe)
		else $error("reply still driven after frame end");
	a_reply_in_frame: assert property ($rose(reply_oe) |-> !bus_select_n)
		else $error("reply driven outside a frame");
	a_reply_idle: assert property (!reply_oe |-> reply_out && reply_line)
		else $error("reply line not high while released");
	a_boot_steady: assert property (!bus_select_n |=> $stable(boot))
		else $error("boot pins moved during a frame");
	a_boot_legal: assert property (boot != 2'b01 && boot != 2'b10)
		else $error("reserved boot code driven");
	a_sclk_idle: assert property (bus_select_n [*4] |-> sclk)
		else $error("serial clock not idle high");
	a_sclk_low_half: assert property ($fell(sclk) |-> !sclk [*4])
		else $error("serial clock low phase too short");
	a_frame_gap: assert property ($rose(bus_select_n) |-> bus_select_n [*8])
		else $error("gap between frames too short");
	a_data_on_low: assert property (!bus_select_n && $past(!bus_select_n)
		&& $changed(bus_command_in) |-> !sclk)
		else $error("command data moved while clock high");
	// main scenarios seen
	c_reply: cover property ($rose(reply_oe));
	c_frame: cover property ($rose(bus_select_n));
	c_boot_off: cover property ($fell(boot_select_high_pin));
endmodule // ilmc_checker
`default_nettype wire

/* File: verification/tb.sv */
// top testbench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
	$display("FAIL %s exp %h got %h", n, e, s); end end
module tb;
	import ilmc_pkg::*;
	localparam int MW = 8; // short image keeps the run brief
	localparam logic [15:0] IDC = 16'h3C5A; // arbitrary value
	localparam logic [15:0] ACT = 16'h7E21; // arbitrary value
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q, c1, c2;
	logic hreadyout, hresp, operational, idle_mode, rx_active, tx_active, locked, param_strobe;
	logic [15:0] power_enables, output_gain, param_word, seen_param, w, v, r, p;
	logic [2:0] rx_amp, tx_amp;
	logic [7:0] ra [6];
	logic [15:0] re [6];
	int errors = 0, num_checks = 0, seed = 32'hda547099;
	ilmc_if lnk ();
	ilmc_host #(.MAX_WORDS(MW)) ilmc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'd2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lnk(lnk));
	ilmc_device #(.ID_CODE(IDC), .ACT_CODE(ACT), .MAX_WORDS(MW)) ilmc_device_inst (.hclk(hclk),
		.hresetn(hresetn), .lnk(lnk), .operational(operational), .idle_mode(idle_mode),
		.rx_active(rx_active), .tx_active(tx_active), .locked(locked),
		.power_enables(power_enables), .output_gain(output_gain), .rx_amp(rx_amp),
		.tx_amp(tx_amp), .param_word(param_word), .param_strobe(param_strobe));
	ilmc_checker ilmc_checker_inst (.hclk(hclk), .hresetn(hresetn), .sclk(lnk.sclk),
		.bus_select_n(lnk.bus_select_n), .bus_command_in(lnk.bus_command_in),
		.reply_out(lnk.reply_out), .reply_oe(lnk.reply_oe), .reply_line(lnk.reply_line),
		.boot_select_high_pin(lnk.boot_select_high_pin),
		.boot_select_low_pin(lnk.boot_select_low_pin));
	// ****
	// clock, monitors, tasks
	// ****
	always #50 hclk = ~hclk;
	// the strobe lasts one cycle, so catch its word here
	always @(posedge hclk) if (param_strobe) seen_param <= param_word;
	function automatic logic [31:0] mix(input logic [31:0] c, input logic [15:0] d);
		return {c[30:0], c[31]} ^ {16'h0, d};
	endfunction
	// one single ahb transfer, zero or more waits
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// one serial frame, waiting for busy to drop
	task automatic cmd(input logic [7:0] a, input logic [1:0] nb, input logic [15:0] d);
		int t;
		ahb(1, HR_WDATA, {16'h0, d});
		ahb(1, HR_CMD, {22'h0, nb, a});
		repeat (4) @(posedge hclk);
		t = 0;
		do begin
			ahb(0, HR_STAT, 0);
			t++;
		end while (q[0] !== 1'b0 && t < 4000);
		if (t >= 4000)
			errors++; // busy never dropped
		ahb(0, HR_RDATA, 0);
		r = q[15:0];
	endtask
	// identity, version and checksums shown or cleared
	task automatic ids(input logic on);
		ra = '{ADR_IDENT, ADR_VERSION, ADR_CSUM1_HI, ADR_CSUM1_LO, ADR_CSUM2_HI, ADR_CSUM2_LO};
		re = '{IDC, v, c1[31:16], c1[15:0], c2[31:16], c2[15:0]};
		for (int i = 0; i < 6; i++) begin
			cmd(ra[i], 2, 0);
			`CHK("id reg", on ? re[i] : 16'h0, r)
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#(60000 * 100);
		errors++;
		stop_test();
	end
	// ****
	// main sequence
	// ****
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1;
		repeat (5) @(posedge hclk);
		`CHK("off before load", 1'b0, operational)
		c1 = 0;
		c2 = 0;
		for (int i = 0; i < MW; i++) begin
			w = $random(seed);
			if (i == 0) v = w;
			c1 += w;
			c2 = mix(c2, w);
			cmd(ADR_IMG_DATA, 2, w);
		end
		cmd(ADR_IMG_DATA, 2, w);
		ahb(0, HR_STAT, 0);
		`CHK("overflow", 2'b10, q[1:0])
		cmd(ADR_IMG_END, 2, 0);
		`CHK("idle after load", 1'b1, idle_mode)
		cmd(ADR_STATUS, 2, 0);
		`CHK("status", 4'b0001, r[3:0])
		ids(1);
		w = $random(seed);
		cmd(ADR_PARAM, 2, w);
		`CHK("param", w, seen_param)
		p = $random(seed);
		cmd(ADR_POWER, 2, p);
		`CHK("power", p, power_enables)
		p = $random(seed);
		cmd(ADR_OUT_GAIN, 2, p);
		`CHK("gain", p, output_gain)
		cmd(ADR_ROUTING, 2, 16'h0009);
		`CHK("amps", 6'b100_010, {tx_amp, rx_amp})
		for (int m = 1; m < 5; m++) begin
			repeat (N_REPOLL) @(posedge hclk);
			cmd(ADR_MODE, 2, 16'(m % 4));
			`CHK("mode", {m % 4 == 0, 2'(m % 4)}, {idle_mode, tx_active, rx_active})
			if (m == 3) begin
				cmd(ADR_PARAM, 2, ~w);
				`CHK("param refused", w, seen_param)
			end
		end
		cmd(ADR_ACTIVATE, 2, ACT);
		ids(0);
		ahb(1, HR_BOOT, 0);
		ahb(1, HR_BOOT, 1);
		ahb(0, HR_BOOT, 0);
		`CHK("boot refused", 2'b00, q[1:0])
		`CHK("pins ignored", 1'b1, idle_mode)
		cmd(ADR_GEN_RESET, 0, 0);
		repeat (10) @(posedge hclk);
		`CHK("idle again", 1'b1, idle_mode)
		`CHK("powered down", 16'h0000, power_enables)
		ids(1);
		cmd(ADR_ACTIVATE, 2, ~ACT);
		cmd(ADR_CSUM1_HI, 2, 0);
		`CHK("dead mark", DEAD_MARK, r)
		cmd(ADR_GEN_RESET, 0, 0);
		cmd(ADR_MODE, 2, 1);
		`CHK("locked", 2'b10, {locked, rx_active})
		stop_test();
	end
endmodule // tb
`default_nettype wire
